// file: core/irq_priority_defines.vh
`ifndef IRQ_PRIORITY_DEFINES_VH
`define IRQ_PRIORITY_DEFINES_VH

// register bus geometry
`define PRIO_ADDR_W                 5
`define PRIO_DATA_W                 16
`define PRIO_SRC_N                  20

// register offsets (word index on the register port)
`define PRIO_FLASH_CLOCK_POWER_PINS_OFS 5'h02
`define PRIO_PORTS_DEF_CAN_OFS          5'h03
`define PRIO_SERIAL_PORTS_ABC_OFS       5'h04

// reset values
`define PRIO_FLASH_CLOCK_POWER_PINS_RST 16'h0000
`define PRIO_PORTS_DEF_CAN_RST          16'h0000
`define PRIO_SERIAL_PORTS_ABC_RST       16'h0000

// implemented bits; reserved bits are zero here
`define PRIO_FLASH_CLOCK_POWER_PINS_MASK 16'hFFCF
`define PRIO_PORTS_DEF_CAN_MASK          16'hFFFC
`define PRIO_SERIAL_PORTS_ABC_MASK       16'hFC3F

// field positions (low bit of each 2-bit field), offset 2
`define FLASH_BUFFERS_EMPTY_PRIORITY_LSB 14
`define FLASH_COMMAND_DONE_PRIORITY_LSB  12
`define FLASH_ERROR_PRIORITY_LSB         10
`define PLL_UNLOCK_PRIORITY_LSB          8
`define LOW_VOLTAGE_PRIORITY_LSB         6
`define EXTERNAL_REQUEST_B_PRIORITY_LSB  2
`define EXTERNAL_REQUEST_A_PRIORITY_LSB  0

// field positions, offset 3
`define PORT_D_PRIORITY_LSB              14
`define PORT_E_PRIORITY_LSB              12
`define PORT_F_PRIORITY_LSB              10
`define CAN_MESSAGE_BUFFER_PRIORITY_LSB  8
`define CAN_WAKEUP_PRIORITY_LSB          6
`define CAN_ERROR_PRIORITY_LSB           4
`define CAN_BUS_OFF_PRIORITY_LSB         2

// field positions, offset 4
`define SERIAL0_RECEIVE_FULL_PRIORITY_LSB    14
`define SERIAL1_TRANSMIT_EMPTY_PRIORITY_LSB  12
`define SERIAL1_RECEIVE_FULL_PRIORITY_LSB    10
`define PORT_A_PRIORITY_LSB                  4
`define PORT_B_PRIORITY_LSB                  2
`define PORT_C_PRIORITY_LSB                  0

// field codes
`define PRIO_CODE_DISABLED          2'b00
`define PRIO_LEVEL_RST              2'b00

`endif

// file: core/irq_priority_regs.v
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`include "irq_priority_defines.vh"

// How it works
// - field code 00 disables the source; 01, 10, 11 give levels 0, 1, 2.
// - covered sources only ever present level 0, 1 or 2, never level 3.
// - reset clears every priority field, so every covered source starts disabled.
// - reserved bits read zero and ignore writes in all three registers.
// - offset 2 bits 15-14: flash buffers-empty priority.
// - offset 2 bits 13-12: flash command-complete priority.
// - offset 2 bits 11-10: flash error priority.
// - offset 2 bits 9-8: loss-of-lock priority.
// - offset 2 bits 7-6: low-voltage detector priority.
// - offset 2 bits 3-2: second external request pin priority.
// - offset 2 bits 1-0: first external request pin priority.
// - offset 3 bits 15-10: ports D, E, F priorities.
// - offset 3 bits 9-8: CAN message buffer priority.
// - offset 3 bits 7-6: CAN wake-up priority.
// - offset 3 bits 5-4 CAN error, bits 3-2 CAN bus-off priority.
// - offset 4 bits 15-14: first serial unit receive-full priority.
// - offset 4 bits 13-12: second serial unit transmit-empty priority.
// - offset 4 bits 11-10: second serial unit receive-full priority.
// - offset 4 bits 5-4 port A, bits 3-2 port B priority.
// - offset 4 bits 1-0: port C priority, same encoding.
// - in low power only sources enabled before entry may request wake-up.
module irq_priority_regs (
   input  wire        ref_clk_i,     // system clock, 40 MHz
   input  wire        rst_i,         // synchronous reset, active high
   input  wire [4:0]  addr_i,        // register word index
   input  wire [15:0] wdata_i,       // write data
   input  wire        wr_i,          // write strobe
   input  wire        rd_i,          // read strobe
   input  wire        low_power_i,   // wait or stop state in force
   input  wire [19:0] src_irq_i,     // raw request of each covered source
   output reg  [15:0] rdata_o,       // read data, cycle after the strobe
   output reg  [19:0] src_enable_o,  // source enabled (field non-zero)
   output reg  [39:0] src_level_o,   // 2-bit level per source, 0..2
   output reg         wake_o         // wake-up request to clock control
);

   // stored registers and their next values
   reg  [15:0] prio_flash_clock_power_pins_r;
   reg  [15:0] prio_ports_def_can_r;
   reg  [15:0] prio_serial_ports_abc_r;
   reg  [15:0] prio_flash_clock_power_pins_nxt;
   reg  [15:0] prio_ports_def_can_nxt;
   reg  [15:0] prio_serial_ports_abc_nxt;
   reg  [15:0] rdata_nxt;
   reg  [19:0] wake_en_r;           // enables frozen at low-power entry
   reg  [19:0] wake_en_nxt;
   wire [19:0] src_enable_nxt;
   wire [39:0] src_level_nxt;
   wire [39:0] field_vec;

   // named fields of the next register values
   wire [1:0] flash_buffers_empty_priority;
   wire [1:0] flash_command_done_priority;
   wire [1:0] flash_error_priority;
   wire [1:0] pll_unlock_priority;
   wire [1:0] low_voltage_priority;
   wire [1:0] external_request_b_priority;
   wire [1:0] external_request_a_priority;
   wire [1:0] port_d_priority;
   wire [1:0] port_e_priority;
   wire [1:0] port_f_priority;
   wire [1:0] can_message_buffer_priority;
   wire [1:0] can_wakeup_priority;
   wire [1:0] can_error_priority;
   wire [1:0] can_bus_off_priority;
   wire [1:0] serial0_receive_full_priority;
   wire [1:0] serial1_transmit_empty_priority;
   wire [1:0] serial1_receive_full_priority;
   wire [1:0] port_a_priority;
   wire [1:0] port_b_priority;
   wire [1:0] port_c_priority;

   // write path: only implemented bits are stored
   always @* begin
      prio_flash_clock_power_pins_nxt = prio_flash_clock_power_pins_r;
      prio_ports_def_can_nxt          = prio_ports_def_can_r;
      prio_serial_ports_abc_nxt       = prio_serial_ports_abc_r;
      if (wr_i) begin
         case (addr_i)
            `PRIO_FLASH_CLOCK_POWER_PINS_OFS: begin
               prio_flash_clock_power_pins_nxt =
                  wdata_i & `PRIO_FLASH_CLOCK_POWER_PINS_MASK;
            end
            `PRIO_PORTS_DEF_CAN_OFS: begin
               prio_ports_def_can_nxt = wdata_i & `PRIO_PORTS_DEF_CAN_MASK;
            end
            `PRIO_SERIAL_PORTS_ABC_OFS: begin
               prio_serial_ports_abc_nxt = wdata_i & `PRIO_SERIAL_PORTS_ABC_MASK;
            end
            default: begin
               prio_flash_clock_power_pins_nxt = prio_flash_clock_power_pins_r;
            end
         endcase
      end
   end

   // read path: stored values, unmapped words read zero
   always @* begin
      rdata_nxt = 16'h0000;
      if (rd_i) begin
         case (addr_i)
            `PRIO_FLASH_CLOCK_POWER_PINS_OFS: begin
               rdata_nxt = prio_flash_clock_power_pins_r;
            end
            `PRIO_PORTS_DEF_CAN_OFS: begin
               rdata_nxt = prio_ports_def_can_r;
            end
            `PRIO_SERIAL_PORTS_ABC_OFS: begin
               rdata_nxt = prio_serial_ports_abc_r;
            end
            default: begin
               rdata_nxt = 16'h0000;
            end
         endcase
      end
   end

   // field extraction, offset 2
   assign flash_buffers_empty_priority =
      prio_flash_clock_power_pins_nxt[`FLASH_BUFFERS_EMPTY_PRIORITY_LSB +: 2];
   assign flash_command_done_priority =
      prio_flash_clock_power_pins_nxt[`FLASH_COMMAND_DONE_PRIORITY_LSB +: 2];
   assign flash_error_priority =
      prio_flash_clock_power_pins_nxt[`FLASH_ERROR_PRIORITY_LSB +: 2];
   assign pll_unlock_priority =
      prio_flash_clock_power_pins_nxt[`PLL_UNLOCK_PRIORITY_LSB +: 2];
   assign low_voltage_priority =
      prio_flash_clock_power_pins_nxt[`LOW_VOLTAGE_PRIORITY_LSB +: 2];
   assign external_request_b_priority =
      prio_flash_clock_power_pins_nxt[`EXTERNAL_REQUEST_B_PRIORITY_LSB +: 2];
   assign external_request_a_priority =
      prio_flash_clock_power_pins_nxt[`EXTERNAL_REQUEST_A_PRIORITY_LSB +: 2];

   // field extraction, offset 3
   assign port_d_priority = prio_ports_def_can_nxt[`PORT_D_PRIORITY_LSB +: 2];
   assign port_e_priority = prio_ports_def_can_nxt[`PORT_E_PRIORITY_LSB +: 2];
   assign port_f_priority = prio_ports_def_can_nxt[`PORT_F_PRIORITY_LSB +: 2];
   assign can_message_buffer_priority =
      prio_ports_def_can_nxt[`CAN_MESSAGE_BUFFER_PRIORITY_LSB +: 2];
   assign can_wakeup_priority =
      prio_ports_def_can_nxt[`CAN_WAKEUP_PRIORITY_LSB +: 2];
   assign can_error_priority =
      prio_ports_def_can_nxt[`CAN_ERROR_PRIORITY_LSB +: 2];
   assign can_bus_off_priority =
      prio_ports_def_can_nxt[`CAN_BUS_OFF_PRIORITY_LSB +: 2];

   // field extraction, offset 4
   assign serial0_receive_full_priority =
      prio_serial_ports_abc_nxt[`SERIAL0_RECEIVE_FULL_PRIORITY_LSB +: 2];
   assign serial1_transmit_empty_priority =
      prio_serial_ports_abc_nxt[`SERIAL1_TRANSMIT_EMPTY_PRIORITY_LSB +: 2];
   assign serial1_receive_full_priority =
      prio_serial_ports_abc_nxt[`SERIAL1_RECEIVE_FULL_PRIORITY_LSB +: 2];
   assign port_a_priority = prio_serial_ports_abc_nxt[`PORT_A_PRIORITY_LSB +: 2];
   assign port_b_priority = prio_serial_ports_abc_nxt[`PORT_B_PRIORITY_LSB +: 2];
   assign port_c_priority = prio_serial_ports_abc_nxt[`PORT_C_PRIORITY_LSB +: 2];

   // source order, index 19 first (most significant), index 0 last
   assign field_vec = {serial0_receive_full_priority,    // 19
                       serial1_transmit_empty_priority,  // 18
                       serial1_receive_full_priority,    // 17
                       port_a_priority,                  // 16
                       port_b_priority,                  // 15
                       port_c_priority,                  // 14
                       port_d_priority,                  // 13
                       port_e_priority,                  // 12
                       port_f_priority,                  // 11
                       can_message_buffer_priority,      // 10
                       can_wakeup_priority,              // 9
                       can_error_priority,               // 8
                       can_bus_off_priority,             // 7
                       flash_buffers_empty_priority,     // 6
                       flash_command_done_priority,      // 5
                       flash_error_priority,             // 4
                       pll_unlock_priority,              // 3
                       low_voltage_priority,             // 2
                       external_request_b_priority,      // 1
                       external_request_a_priority};     // 0

   // per-source decode: code minus one, disabled presents level 0
   genvar g;
   generate
      for (g = 0; g < `PRIO_SRC_N; g = g + 1) begin : g_src
         assign src_enable_nxt[g] =
            (field_vec[2*g +: 2] != `PRIO_CODE_DISABLED);
         assign src_level_nxt[2*g +: 2] = src_enable_nxt[g] ?
            (field_vec[2*g +: 2] - 2'b01) : `PRIO_LEVEL_RST;
      end
   endgenerate

   // wake enables track the fields until low power is entered
   always @* begin
      wake_en_nxt = wake_en_r;
      if (!low_power_i) begin
         wake_en_nxt = src_enable_o;
      end
   end

   // register update
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         prio_flash_clock_power_pins_r <= `PRIO_FLASH_CLOCK_POWER_PINS_RST;
         prio_ports_def_can_r          <= `PRIO_PORTS_DEF_CAN_RST;
         prio_serial_ports_abc_r       <= `PRIO_SERIAL_PORTS_ABC_RST;
         src_enable_o                  <= 20'h0_0000;
         src_level_o                   <= 40'h00_0000_0000;
         wake_en_r                     <= 20'h0_0000;
         wake_o                        <= 1'b0;
         rdata_o                       <= 16'h0000;
      end else begin
         prio_flash_clock_power_pins_r <= prio_flash_clock_power_pins_nxt;
         prio_ports_def_can_r          <= prio_ports_def_can_nxt;
         prio_serial_ports_abc_r       <= prio_serial_ports_abc_nxt;
         src_enable_o                  <= src_enable_nxt;
         src_level_o                   <= src_level_nxt;
         wake_en_r                     <= wake_en_nxt;
         wake_o <= low_power_i & (|(src_irq_i & wake_en_nxt));
         rdata_o                       <= rdata_nxt;
      end
   end

endmodule

// file: test/core_arbiter_model.sv
`timescale 1ns/1ps
module core_arbiter_model (
   input  wire logic [19:0] src_enable_i, // per-source enable
   input  wire logic [39:0] src_level_i,  // per-source level
   input  wire logic [19:0] src_irq_i,    // raw requests
   output logic             pending_o,    // an enabled source requests
   output logic [1:0]       top_level_o,  // highest requesting level
   output logic             bad_level_o   // level 3 was presented
);
   // pick the highest level among enabled requesting sources
   always_comb begin
      pending_o = 1'b0;
      top_level_o = 2'b00;
      bad_level_o = 1'b0;
      for (int i = 0; i < 20; i++) begin
         if (&src_level_i[2*i+:2]) bad_level_o = 1'b1;
         if (src_enable_i[i] && src_irq_i[i]) begin
            pending_o = 1'b1;
            if (src_level_i[2*i+:2] > top_level_o) top_level_o = src_level_i[2*i+:2];
         end
      end
   end
endmodule

// file: test/irq_priority_checker.sv
`timescale 1ns/1ps
module irq_priority_checker (
   input wire        ref_clk_i,    // system clock
   input wire        rst_i,        // synchronous reset
   input wire [4:0]  addr_i,       // word index
   input wire [15:0] wdata_i,      // write data
   input wire        wr_i,         // write strobe
   input wire        rd_i,         // read strobe
   input wire        low_power_i,  // low-power state
   input wire [19:0] src_irq_i,    // raw requests
   input wire [15:0] rdata_o,      // read data
   input wire [19:0] src_enable_o, // source enables
   input wire [39:0] src_level_o,  // source levels
   input wire        wake_o        // wake request
);
   logic       any_top;
   logic       bad_off;
   wire  [1:0] port_c_code = wdata_i[1:0];
   // flag a forbidden level or a level on a disabled source
   always_comb begin
      any_top = 1'b0;
      bad_off = 1'b0;
      for (int i = 0; i < 20; i++) begin
         any_top = any_top | (&src_level_o[2*i+:2]);
         bad_off = bad_off | (!src_enable_o[i] && src_level_o[2*i+:2] != 2'b00);
      end
   end
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   // write to offset 3 followed at once by a read of it
   sequence wr_then_rd;
      wr_i && addr_i == 5'h03 ##1 rd_i && addr_i == 5'h03;
   endsequence
   reset_clears_a: assert property ($past(rst_i) |-> src_enable_o == 20'h0_0000 && !wake_o)
      else $error("outputs not cleared by reset");
   level_range_a: assert property (!any_top)
      else $error("level 3 presented");
   disabled_zero_a: assert property (!bad_off)
      else $error("level shown on disabled source");
   read_idle_a: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
      else $error("read data outside read cycle");
   reserved_read_a: assert property ($past(rd_i) && $past(addr_i) == 5'h04 |-> rdata_o[9:6] == 4'h0)
      else $error("reserved bits read non-zero");
   readback_a: assert property (wr_then_rd |=> rdata_o == ($past(wdata_i, 2) & 16'hFFFC))
      else $error("read after write mismatch");
   port_c_level_a: assert property (wr_i && addr_i == 5'h04 && port_c_code != 2'b00 |=>
      src_enable_o[14] && src_level_o[29:28] + 2'b01 == $past(port_c_code))
      else $error("port c level wrong");
   wake_idle_a: assert property (!low_power_i |=> !wake_o)
      else $error("wake outside low power");
   wake_quiet_a: assert property (low_power_i && src_irq_i == 20'h0_0000 |=> !wake_o)
      else $error("wake without request");
endmodule

// file: test/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic ref_clk_i, rst_i, wr_i, rd_i, low_power_i, pending, bad_level, wake_o;
   logic [4:0] addr_i;
   logic [15:0] wdata_i, rdata_o;
   logic [19:0] src_irq_i, src_enable_o;
   logic [39:0] src_level_o;
   logic [1:0] top_level, cd;
   int n_mismatch = 0, total_checks = 0, cycles = 0;
   int lsb_t[20] = '{0, 2, 6, 8, 10, 12, 14, 2, 4, 6, 8, 10, 12, 14, 0, 2, 4, 10, 12, 14};
   irq_priority_regs irq_priority_regs_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .low_power_i(low_power_i),
      .src_irq_i(src_irq_i), .rdata_o(rdata_o), .src_enable_o(src_enable_o),
      .src_level_o(src_level_o), .wake_o(wake_o));
   core_arbiter_model core_arbiter_model_inst (.src_enable_i(src_enable_o),
      .src_level_i(src_level_o), .src_irq_i(src_irq_i), .pending_o(pending),
      .top_level_o(top_level), .bad_level_o(bad_level));
   task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge ref_clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [15:0] exp);
      @(posedge ref_clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      @(negedge ref_clk_i);
      cmp(rdata_o, exp);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // clock and cycle ceiling
   initial begin
      ref_clk_i = 1'b0;
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   // main sequence
   initial begin
      {rst_i, wr_i, rd_i, low_power_i, addr_i, wdata_i, src_irq_i} = '0;
      rst_i = 1'b1;
      repeat (5) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      for (int a = 2; a < 5; a++) rd(a[4:0], 16'h0000);
      cmp(src_enable_o, 40'h0);
      cmp(src_level_o, 40'h0);
      for (int i = 0; i < 20; i++) begin
         wr(i < 7 ? 5'h02 : (i < 14 ? 5'h03 : 5'h04), 16'h0003 << lsb_t[i]);
         @(negedge ref_clk_i);
         cmp(src_enable_o, 40'h1 << i);
         cmp(src_level_o, 40'h2 << (2 * i));
         wr(i < 7 ? 5'h02 : (i < 14 ? 5'h03 : 5'h04), 16'h0000);
      end
      src_irq_i <= 20'hF_FFFF;
      for (int c = 0; c < 4; c++) begin
         cd = c[1:0];
         for (int a = 2; a < 5; a++) wr(a[4:0], {8{cd}});
         @(negedge ref_clk_i);
         cmp(src_enable_o, cd == 2'b00 ? 20'h0_0000 : 20'hF_FFFF);
         cmp(src_level_o, cd == 2'b00 ? 40'h0 : {20{cd - 2'b01}});
         cmp({pending, top_level, bad_level}, {cd != 2'b00, cd == 2'b00 ? 2'b00 : cd - 2'b01, 1'b0});
         rd(5'h02, {8{cd}} & 16'hFFCF);
         rd(5'h03, {8{cd}} & 16'hFFFC);
         rd(5'h04, {8{cd}} & 16'hFC3F);
      end
      wr(5'h05, 16'hFFFF);
      wr(5'h00, 16'h0000);
      rd(5'h05, 16'h0000);
      rd(5'h02, 16'hFFCF);
      @(posedge ref_clk_i);
      wr_i <= 1'b1;
      addr_i <= 5'h03;
      wdata_i <= 16'h5A5A;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
      rd_i <= 1'b1;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      @(negedge ref_clk_i);
      cmp(rdata_o, 16'h5A58);
      for (int a = 2; a < 5; a++) wr(a[4:0], 16'h0000);
      wr(5'h02, 16'h0001);
      @(posedge ref_clk_i);
      low_power_i <= 1'b1;
      src_irq_i <= 20'h0_0002;
      wr(5'h02, 16'h0005);
      repeat (2) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      cmp(wake_o, 1'b0);
      @(posedge ref_clk_i);
      src_irq_i <= 20'h0_0001;
      @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      cmp(wake_o, 1'b1);
      @(posedge ref_clk_i);
      low_power_i <= 1'b0;
      @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      cmp(wake_o, 1'b0);
      @(posedge ref_clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      rd(5'h02, 16'h0000);
      end_of_test();
   end
endmodule
bind irq_priority_regs irq_priority_checker irq_priority_checker_inst (.ref_clk_i(ref_clk_i),
   .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
   .low_power_i(low_power_i), .src_irq_i(src_irq_i), .rdata_o(rdata_o),
   .src_enable_o(src_enable_o), .src_level_o(src_level_o), .wake_o(wake_o));
